// ===== bench/access_source.sv
`timescale 1ns/1ps
module access_source (
  // Clock and answer
  input  wire logic  core_clk,
  input  wire logic  rspValid,
  input  wire logic  rspDenied,
  // Request
  output logic       reqValid,
  output logic [2:0] reqOp,
  output logic[16:0] reqAddr,
  output logic[31:0] reqWdata
);
  initial reqValid = 1'b0;
  // Released lines invert, so a stale value never matches by luck
  task automatic acc(input logic [2:0] o, input logic [16:0] a, input logic [31:0] d,
                     output logic dn);
    @(negedge core_clk);
    {reqValid, reqOp, reqAddr, reqWdata} = {1'b1, o, a, d};
    dn = 1'b0;
    repeat (300) begin
      @(negedge core_clk);
      {reqValid, reqOp, reqAddr, reqWdata} = {1'b0, ~o, ~a, ~d};
      if (rspValid) begin
        dn = rspDenied;
        break;
      end
    end
  endtask
endmodule

// ===== bench/fbep_checker.sv
`timescale 1ns/1ps
module fbep_checker (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Request and config
  input wire logic       reqValid,
  input wire logic [2:0] reqOp,
  input wire logic[16:0] reqAddr,
  input wire logic       cfgWe,
  input wire logic [5:0] cfgUnit,
  input wire logic [1:0] cfgMode,
  // Answer
  input wire logic       rspValid,
  input wire logic       rspDenied,
  input wire logic       violFlag,
  input wire logic [2:0] violOp
);
  logic       busy_ff;
  logic [1:0] mode_ff [64];
  wire  [1:0] um = mode_ff[reqAddr[16:11]];
  // The design is free again in the cycle that the erase answer shows
  wire        tk = reqValid && reqOp != 3'h0 && (!busy_ff || rspValid);
  wire        ersOk = tk && reqOp == 3'h5 && um != 2'h1 && um != 2'h2;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      for (int i = 0; i < 64; i++) mode_ff[i] <= 2'h0;
    end else begin
      if (ersOk) busy_ff <= 1'b1;
      else if (rspValid) busy_ff <= 1'b0;
      if (cfgWe) mode_ff[cfgUnit] <= cfgMode;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_ers; tk && reqOp == 3'h5; endsequence
  sequence s_den; tk ##1 rspDenied; endsequence
  property p_ers; s_ers |=> rspDenied or ##256 rspValid; endproperty
  property p_fast; tk && reqOp != 3'h5 |=> rspValid; endproperty
  property p_den; rspDenied |-> rspValid && violFlag; endproperty
  property p_vop; s_den |-> violOp == $past(reqOp); endproperty
  property p_ro; tk && reqOp inside {3'h4, 3'h5} && um inside {2'h1, 2'h2} |=> rspDenied; endproperty
  property p_xo; tk && reqOp inside {3'h2, 3'h3} && um == 2'h2 |=> rspDenied; endproperty
  property p_fch; tk && reqOp == 3'h1 |=> !rspDenied; endproperty
  property p_opn; tk && um[0] == um[1] |=> !rspDenied; endproperty
  a_ers: assert property (p_ers) else $error("erase answer late");
  a_fast: assert property (p_fast) else $error("answer late");
  a_den: assert property (p_den) else $error("denial bad");
  a_vop: assert property (p_vop) else $error("violOp bad");
  a_ro: assert property (p_ro) else $error("write passed");
  a_xo: assert property (p_xo) else $error("read passed");
  a_fch: assert property (p_fch) else $error("fetch denied");
  a_opn: assert property (p_opn) else $error("open denied");
endmodule
bind flash_block_erase_protect fbep_checker u_chk (.*);

// ===== bench/flash_block_erase_protect_tb.sv
`timescale 1ns/1ps
module flash_block_erase_protect_tb;
  logic core_clk, rst, cfgWe, violClr, dn;
  logic [5:0] cfgUnit;
  logic [1:0] cfgMode;
  wire reqValid, rspValid, rspDenied, violFlag;
  wire [2:0] reqOp, violOp;
  wire[16:0] reqAddr;
  wire[31:0] reqWdata, rspRdata;
  int badCount = 0, testsRun = 0, cyc = 0;
  flash_block_erase_protect DUT (.*);
  access_source src (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic completeRun;
    if (badCount == 0 && testsRun > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] m);
    @(negedge core_clk);
    {cfgWe, cfgUnit, cfgMode} = {1'b1, 6'h01, m};
    @(negedge core_clk);
    cfgWe = 1'b0;
  endtask
  task automatic openUnit;
    src.acc(3'h5, 17'h0_0804, 32'h0, dn);
    src.acc(3'h2, 17'h0_0BFC, 32'h0, dn); chk(rspRdata, 32'hFFFF_FFFF);
    src.acc(3'h4, 17'h0_0800, 32'h0000_1234, dn);
    src.acc(3'h2, 17'h0_0800, 32'h0, dn); chk(rspRdata, 32'h0000_1234);
  endtask
  task automatic roUnit;
    cfg(2'h1);
    src.acc(3'h5, 17'h0_0800, 32'h0, dn); chk({31'h0, dn}, 32'h1);
    chk({28'h0, violFlag, violOp}, 32'hD);
    src.acc(3'h2, 17'h0_0800, 32'h0, dn); chk(rspRdata, 32'h0000_1234);
  endtask
  task automatic xoUnit;
    cfg(2'h2);
    for (logic [2:0] o = 3'h2; o < 3'h6; o++) begin
      src.acc(o, 17'h0_0800, 32'h0, dn); chk({31'h0, dn}, 32'h1);
      if (o < 3'h4) chk(rspRdata, 32'h0000_0000);
    end
    src.acc(3'h1, 17'h0_0800, 32'h0, dn); chk(rspRdata, 32'h0000_1234);
    violClr = 1'b1;
    @(negedge core_clk);
    violClr = 1'b0;
    chk({31'h0, violFlag}, 32'h0);
  endtask
  initial begin
    {rst, cfgWe, violClr, cfgUnit, cfgMode} = {3'h4, 8'h00};
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    openUnit;
    roUnit;
    xoUnit;
    completeRun;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      badCount++;
      completeRun;
    end
  end
endmodule

// ===== design/flash_block_erase_protect.v
// Overview of operation
// [RULE1] Flash array of 128 KB, processor addressable
// [RULE2] Erase in 1 KB blocks, neighbours untouched
// [RULE3] Erased block reads back all ones
// [RULE4] Protection per 2 KB unit, three modes
// [RULE5] Read-only units refuse erase and program
// [RULE6] Execute-only: no erase/program, fetch reads only
// [RULE7] Execute-only denies data and debugger reads
// [RULE8] Refusals leave contents, raise status flag
`timescale 1ns/1ps
`include "flash_prot_defs.vh"

module flash_block_erase_protect #(
  parameter ADDR_W    = `FP_ADDR_W,
  parameter DATA_W    = `FP_DATA_W,
  parameter NUM_UNITS = `FP_NUM_UNITS
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              rst,
  // Access request
  input  wire              reqValid,
  input  wire [2:0]        reqOp,
  input  wire [ADDR_W-1:0] reqAddr,
  input  wire [DATA_W-1:0] reqWdata,
  // Access answer
  output reg               rspValid,
  output reg               rspDenied,
  output reg  [DATA_W-1:0] rspRdata,
  // Protection configuration
  input  wire              cfgWe,
  input  wire [5:0]        cfgUnit,
  input  wire [1:0]        cfgMode,
  // Violation status
  input  wire              violClr,
  output reg               violFlag,
  output reg  [2:0]        violOp
);

  localparam WORDS     = (1 << ADDR_W) / (DATA_W / 8);
  localparam WIDX_W    = ADDR_W - 2;
  localparam BW_W      = `FP_BLOCK_SHIFT - 2;
  // Last word of a block; a block holds a power of two words
  localparam [BW_W-1:0] CNT_LAST = {BW_W{1'b1}};

  // ----------------------------------------
  // Storage and erase sequencer state
  // ----------------------------------------
  reg [DATA_W-1:0] mem [0:WORDS-1]; // see [RULE1]
  reg              busy_ff;
  reg [WIDX_W-1:0] eraseIdx_ff;
  reg [BW_W-1:0]   eraseCnt_ff;

  wire [2*NUM_UNITS-1:0] modes;
  wire [WIDX_W-1:0]      wordIdx = reqAddr[ADDR_W-1:2];
  wire [5:0]             unitIdx = reqAddr[ADDR_W-1:`FP_UNIT_SHIFT];
  wire [1:0]             unitMode = modes[2*unitIdx +: 2];

  genvar g;
  generate
    for (g = 0; g < NUM_UNITS; g = g + 1) begin : gUnit
      // Unit number held at the select width, so the compare is exact
      localparam [5:0] UNIT_ID = g;
      prot_unit_cell uCell (
        .core_clk (core_clk),
        .rst      (rst),
        .cfgWe    (cfgWe && (cfgUnit == UNIT_ID)),
        .cfgMode  (cfgMode),
        .mode     (modes[2*g +: 2])
      );
    end
  endgenerate

  // ----------------------------------------
  // Access decision
  // ----------------------------------------
  wire unitRo = (unitMode == `FP_MODE_RDONLY);
  wire unitXo = (unitMode == `FP_MODE_XONLY);

  reg deny;
  always @* begin
    deny = 1'b0;
    case (reqOp)
      `FP_OP_PROG, `FP_OP_ERASE:
        deny = unitRo || unitXo; // see [RULE5] see [RULE6]
      `FP_OP_DREAD, `FP_OP_DBGREAD:
        deny = unitXo; // see [RULE7]
      default: deny = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  // Requests seen while an erase runs are dropped, not queued: the
  // requester waits for each answer before it asks again.
  wire take = reqValid && !busy_ff && (reqOp != `FP_OP_NONE);

  // ----------------------------------------
  // Erase walk, next state
  // ----------------------------------------
  // An erase takes one word a cycle; new requests wait for it to finish
  // so that a read never sees a half-erased block.
  reg              nxt_busy;
  reg [WIDX_W-1:0] nxt_eraseIdx;
  reg [BW_W-1:0]   nxt_eraseCnt;
  reg              eraseDone;
  always @* begin
    nxt_busy     = busy_ff;
    nxt_eraseIdx = eraseIdx_ff;
    nxt_eraseCnt = eraseCnt_ff;
    eraseDone    = 1'b0;
    if (busy_ff) begin
      nxt_eraseIdx = eraseIdx_ff + 1'b1;
      nxt_eraseCnt = eraseCnt_ff + 1'b1;
      if (eraseCnt_ff == CNT_LAST) begin
        nxt_busy  = 1'b0;
        eraseDone = 1'b1;
      end
    end else if (take && !deny && (reqOp == `FP_OP_ERASE)) begin
      nxt_busy     = 1'b1; // see [RULE2]
      nxt_eraseIdx = {reqAddr[ADDR_W-1:`FP_BLOCK_SHIFT], {BW_W{1'b0}}};
      nxt_eraseCnt = {BW_W{1'b0}};
    end
  end

  // ----------------------------------------
  // Response, next state
  // ----------------------------------------
  // Read data is held until the next answer other than an erase; refusals show zeros so
  // nothing protected leaks through a stale word.
  reg              nxt_rspValid;
  reg              nxt_rspDenied;
  reg [DATA_W-1:0] nxt_rspRdata;
  always @* begin
    nxt_rspValid  = 1'b0;
    nxt_rspDenied = 1'b0;
    nxt_rspRdata  = rspRdata;
    if (busy_ff) begin
      nxt_rspValid = eraseDone;
    end else if (take) begin
      if (deny) begin
        nxt_rspValid  = 1'b1;
        nxt_rspDenied = 1'b1;
        nxt_rspRdata  = {DATA_W{1'b0}}; // see [RULE7]
      end else if (reqOp == `FP_OP_PROG) begin
        nxt_rspValid = 1'b1;
        nxt_rspRdata = {DATA_W{1'b0}};
      end else if (reqOp != `FP_OP_ERASE) begin
        nxt_rspValid = 1'b1;
        nxt_rspRdata = mem[wordIdx]; // see [RULE6]
      end
    end
  end

  // ----------------------------------------
  // Registered response and erase state
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rspValid    <= 1'b0;
      rspDenied   <= 1'b0;
      rspRdata    <= {DATA_W{1'b0}};
      busy_ff     <= 1'b0;
      eraseIdx_ff <= {WIDX_W{1'b0}};
      eraseCnt_ff <= {BW_W{1'b0}};
    end else begin
      rspValid    <= nxt_rspValid;
      rspDenied   <= nxt_rspDenied;
      rspRdata    <= nxt_rspRdata;
      busy_ff     <= nxt_busy;
      eraseIdx_ff <= nxt_eraseIdx;
      eraseCnt_ff <= nxt_eraseCnt;
    end
  end

  // Array has no reset: contents are non-volatile in intent
  always @(posedge core_clk) begin
    if (busy_ff) begin
      mem[eraseIdx_ff] <= `FP_ERASED_WORD; // see [RULE3]
    end else if (take && !deny && reqOp == `FP_OP_PROG) begin
      mem[wordIdx] <= mem[wordIdx] & reqWdata; // Programming only clears bits
    end
  end

  // ----------------------------------------
  // Violation status, set wins over clear
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      violFlag <= 1'b0;
      violOp   <= `FP_OP_NONE;
    end else if (take && deny) begin
      violFlag <= 1'b1; // see [RULE8]
      violOp   <= reqOp;
    end else if (violClr) begin
      violFlag <= 1'b0;
    end
  end

endmodule

// ===== design/flash_prot_defs.vh
`ifndef FLASH_PROT_DEFS_VH
`define FLASH_PROT_DEFS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define FP_FLASH_BYTES   131072
`define FP_ADDR_W        17
`define FP_BLOCK_BYTES   1024
`define FP_BLOCK_SHIFT   10
`define FP_UNIT_SHIFT    11
`define FP_NUM_BLOCKS    128
`define FP_NUM_UNITS     64
`define FP_DATA_W        32

// ----------------------------------------
// Protection modes
// ----------------------------------------
`define FP_MODE_OPEN     2'h0
`define FP_MODE_RDONLY   2'h1
`define FP_MODE_XONLY    2'h2

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define FP_OP_NONE       3'h0
`define FP_OP_FETCH      3'h1
`define FP_OP_DREAD      3'h2
`define FP_OP_DBGREAD    3'h3
`define FP_OP_PROG       3'h4
`define FP_OP_ERASE      3'h5

`define FP_ERASED_WORD   32'hFFFF_FFFF

`endif

// ===== design/prot_unit_cell.v
`timescale 1ns/1ps
`include "flash_prot_defs.vh"

module prot_unit_cell (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Configuration
  input  wire       cfgWe,
  input  wire [1:0] cfgMode,
  // State
  output wire [1:0] mode
);

  reg [1:0] mode_ff;

  // ----------------------------------------
  // Per-unit protection setting
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= `FP_MODE_OPEN;
    end else if (cfgWe) begin
      mode_ff <= cfgMode; // see [RULE4]
    end
  end

  assign mode = mode_ff;

endmodule
